/* hdl/mcps_card.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mcps_regs.svh"
module mcps_card
    import mcps_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    mcps_link_if.card link,
    input wire logic tasks_done,
    input wire logic tasks_fail,
    output logic tasks_start,
    output logic pmu_supply_regulator_en,
    output logic rtc_supply_regulator_en,
    output logic core_regs_en,
    output logic card_rst,
    output logic sysclk_req,
    output logic card_running
);

    mcps_card_s r;
    mcps_card_s next_r;
    logic powered;

    // ****************************************
    // next state
    // ****************************************
    // the pin and supply come from another board, so both are synchronised
    always_comb
    begin
        next_r = r;
        next_r.keep_meta = link.keep_on_level;
        next_r.keep_sync = r.keep_meta;
        next_r.sup_meta = link.supply_en;
        next_r.sup_sync = r.sup_meta;
        next_r.tasks_start = 1'b0;
        next_r.rsp_valid = 1'b0;
        next_r.rsp_code = RSP_NONE;
        powered = r.keep_sync && r.sup_sync;
        if (!powered)
        begin
            // low pin (floating reads low only without the board pull-up) or lost supply drops everything, pmu included
            next_r.state = C_OFF;
            next_r.pmu_en = 1'b0;
            next_r.rtc_en = 1'b0;
            next_r.core_en = 1'b0;
            next_r.card_rst = 1'b1;
            next_r.clk_req = 1'b0;
        end
        else
        begin
            case (r.state)
                C_OFF:
                begin
                    // high pin with supply present starts power-up
                    next_r.state = C_UP;
                    next_r.pmu_en = 1'b1;
                    next_r.rtc_en = 1'b1;
                    next_r.core_en = 1'b1;
                    next_r.clk_req = 1'b1;
                    next_r.step = '0;
                end
                C_UP:
                begin
                    // reset held one step while the regulators settle
                    next_r.step = r.step + 11'h1;
                    if (r.step == 11'(`MCPS_STEP_CYC - 1))
                    begin
                        next_r.state = C_ON;
                        next_r.card_rst = 1'b0;
                    end
                    if (link.cmd_valid)
                    begin
                        next_r.rsp_valid = 1'b1;
                        next_r.rsp_code = RSP_ERROR;
                    end
                end
                C_ON:
                begin
                    if (link.cmd_valid && link.cmd_code == CMD_FUNC_MIN)
                    begin
                        // detach, save nvm, sim shutdown are firmware work
                        next_r.state = C_TASKS;
                        next_r.tasks_start = 1'b1;
                    end
                    else if (link.cmd_valid)
                    begin
                        next_r.rsp_valid = 1'b1;
                        next_r.rsp_code = RSP_OK;
                    end
                end
                C_TASKS:
                begin
                    // ok only once the shutdown tasks are complete
                    if (tasks_done)
                    begin
                        next_r.state = C_DOWN;
                        next_r.rsp_valid = 1'b1;
                        next_r.rsp_code = RSP_OK;
                        next_r.phase = 2'h0;
                        next_r.step = '0;
                    end
                    else if (tasks_fail)
                    begin
                        next_r.state = C_ON;
                        next_r.rsp_valid = 1'b1;
                        next_r.rsp_code = RSP_ERROR;
                    end
                end
                C_DOWN:
                begin
                    // three steps, far below one second in total
                    next_r.step = r.step + 11'h1;
                    if (r.step == 11'(`MCPS_STEP_CYC - 1))
                    begin
                        next_r.step = '0;
                        next_r.phase = r.phase + 2'h1;
                        if (r.phase == 2'h0)
                        begin
                            next_r.core_en = 1'b0;
                        end
                        else if (r.phase == 2'h1)
                        begin
                            next_r.card_rst = 1'b1;
                        end
                        else
                        begin
                            next_r.clk_req = 1'b0;
                            next_r.state = C_PARK;
                        end
                    end
                end
                C_PARK:
                begin
                    // only pmu and rtc supplies stay up until the pin or the supply drops
                    if (link.cmd_valid)
                    begin
                        next_r.rsp_valid = 1'b1;
                        next_r.rsp_code = RSP_OK;
                    end
                end
                default:
                begin
                    next_r.state = C_OFF;
                end
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            r <= '{state: C_OFF, card_rst: 1'b1, rsp_code: RSP_NONE, default: '0};
        end
        else
        begin
            r <= next_r;
        end
    end

    // outputs straight from the state flops, card_running decoded from the state field
    assign link.rsp_valid = r.rsp_valid;
    assign link.rsp_code = r.rsp_code;
    assign tasks_start = r.tasks_start;
    assign pmu_supply_regulator_en = r.pmu_en;
    assign rtc_supply_regulator_en = r.rtc_en;
    assign core_regs_en = r.core_en;
    assign card_rst = r.card_rst;
    assign sysclk_req = r.clk_req;
    assign card_running = (r.state == C_ON);

endmodule
`default_nettype wire

/* hdl/mcps_regs.svh */
`ifndef MCPS_REGS_SVH
`define MCPS_REGS_SVH
// ****************************************
// timing constants
// ****************************************
// host clock period in ns
`define MCPS_CLK_PERIOD_NS 8
// fixed hold-off between the ok reply and pin release, in ms
`define MCPS_HOLD_OFF_MS 1000
`define MCPS_HOLD_OFF_CYC ((`MCPS_HOLD_OFF_MS * 1000000) / `MCPS_CLK_PERIOD_NS)
// host-chosen reply timeout, in ms
`define MCPS_RSP_TIMEOUT_MS 1500
`define MCPS_RSP_TIMEOUT_CYC ((`MCPS_RSP_TIMEOUT_MS * 1000000) / `MCPS_CLK_PERIOD_NS)
// card power step length, in us (least time, rounded up)
`define MCPS_STEP_US 10
`define MCPS_STEP_CYC ((`MCPS_STEP_US * 1000 + `MCPS_CLK_PERIOD_NS - 1) / `MCPS_CLK_PERIOD_NS)
// reset values of the pin drivers
`define MCPS_KEEP_OUT_RST 1'b0
`define MCPS_KEEP_OE_RST 1'b1
`endif

/* hdl/mcps_pkg.sv */
`default_nettype none
package mcps_pkg;

    // command channel words
    typedef enum logic [1:0] {CMD_NONE = 2'h0, CMD_FUNC_MIN = 2'h1, CMD_FUNC_FULL = 2'h2} mcps_cmd_e;
    typedef enum logic [1:0] {RSP_NONE = 2'h0, RSP_OK = 2'h1, RSP_ERROR = 2'h2} mcps_rsp_e;

    // host sequencer states
    typedef enum logic [4:0] {
        H_IDLE = 5'h01, H_ON = 5'h02, H_SEND = 5'h04, H_WAIT = 5'h08, H_HOLD = 5'h10
    } mcps_host_e;

    // card sequencer states
    typedef enum logic [5:0] {
        C_OFF = 6'h01, C_UP = 6'h02, C_ON = 6'h04, C_TASKS = 6'h08, C_DOWN = 6'h10, C_PARK = 6'h20
    } mcps_card_e;

    typedef struct packed {
        mcps_host_e state;
        logic keep_out;
        logic keep_oe;
        logic supply;
        logic cmd_valid;
        mcps_cmd_e cmd_code;
        logic [31:0] timer;
        logic [3:0] retries;
        logic timed_out;
    } mcps_host_s;

    typedef struct packed {
        mcps_card_e state;
        logic keep_meta;
        logic keep_sync;
        logic sup_meta;
        logic sup_sync;
        logic [1:0] phase;
        logic [10:0] step;
        logic pmu_en;
        logic rtc_en;
        logic core_en;
        logic card_rst;
        logic clk_req;
        logic tasks_start;
        logic rsp_valid;
        mcps_rsp_e rsp_code;
    } mcps_card_s;

endpackage
`default_nettype wire

/* hdl/mcps_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface mcps_link_if;
    import mcps_pkg::*;

    // keep-on pin: host drive, its enable, and the board pull when undriven
    logic keep_on_out;
    logic keep_on_oe;
    logic board_pullup;
    logic keep_on_level;
    // card supply switch
    logic supply_en;
    // command channel
    logic cmd_valid;
    mcps_cmd_e cmd_code;
    logic rsp_valid;
    mcps_rsp_e rsp_code;

    // an undriven pin reads as the board pull, low when there is none
    assign keep_on_level = keep_on_oe ? keep_on_out : board_pullup;

    modport host
    (
        output keep_on_out,
        output keep_on_oe,
        output supply_en,
        output cmd_valid,
        output cmd_code,
        input rsp_valid,
        input rsp_code
    );

    modport card
    (
        input keep_on_level,
        input supply_en,
        input cmd_valid,
        input cmd_code,
        output rsp_valid,
        output rsp_code
    );
endinterface
`default_nettype wire

/* hdl/mcps_host.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mcps_regs.svh"
module mcps_host
    import mcps_pkg::*;
#(
    // hold-off after the ok and the reply timeout, in host cycles
    parameter int unsigned HOLD_OFF_CYC = `MCPS_HOLD_OFF_CYC,
    parameter int unsigned RSP_TIMEOUT_CYC = `MCPS_RSP_TIMEOUT_CYC
)
(
    input wire logic core_clk,
    input wire logic rst,
    mcps_link_if.host link,
    // requests from software on this clock
    input wire logic power_on_req,
    input wire logic power_off_req,
    // board options: pin tied high, pin released to hi-z
    input wire logic tied_mode,
    input wire logic release_hiz,
    // status back to software
    output logic busy,
    output logic card_powered,
    output logic shutdown_timed_out,
    output logic [3:0] error_retries
);

    mcps_host_s r;
    mcps_host_s next_r;
    logic hold_done;
    logic wait_expired;
    logic got_ok;
    logic got_error;

    // ****************************************
    // decode helpers
    // ****************************************
    // a reply counts only in the cycle its valid pulse stands
    function automatic logic rsp_is(input logic valid, input mcps_rsp_e code, input mcps_rsp_e want);
        return valid && (code == want);
    endfunction

    // last count of a wait of the given length
    function automatic logic timer_at(input logic [31:0] count, input int unsigned limit);
        return count == 32'(limit - 1);
    endfunction

    // ****************************************
    // decode of the card reply
    // ****************************************
    // replies come from logic on this clock, so no synchroniser
    assign got_ok = rsp_is(link.rsp_valid, link.rsp_code, RSP_OK);
    assign got_error = rsp_is(link.rsp_valid, link.rsp_code, RSP_ERROR);
    // one shared timer: only one of the two waits runs at a time
    assign hold_done = timer_at(r.timer, HOLD_OFF_CYC);
    assign wait_expired = timer_at(r.timer, RSP_TIMEOUT_CYC);

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        next_r = r;
        // defaults: the command word is a one-cycle pulse
        next_r.cmd_valid = 1'b0;
        next_r.cmd_code = CMD_NONE;
        case (r.state)
            H_IDLE:
            begin
                // the pin is only driven high on an explicit request
                if (power_on_req)
                begin
                    next_r.state = H_ON;
                    next_r.supply = 1'b1;
                    next_r.keep_out = 1'b1;
                    // tied mode leaves the pin to the board pull-up
                    next_r.keep_oe = !tied_mode;
                    // retry and timeout history kept until the next power-on
                    next_r.timed_out = 1'b0;
                    next_r.retries = 4'h0;
                end
            end
            H_ON:
            begin
                // pin and supply untouched until the handshake is over
                if (power_off_req)
                begin
                    next_r.state = H_SEND;
                end
            end
            H_SEND:
            begin
                // one-cycle command word on the channel
                next_r.cmd_valid = 1'b1;
                next_r.cmd_code = CMD_FUNC_MIN;
                // timer restarts with every send, retries included
                next_r.timer = '0;
                next_r.state = H_WAIT;
            end
            H_WAIT:
            begin
                // timer runs from the command pulse; any reply ends the wait
                next_r.timer = r.timer + 32'h1;
                if (got_ok)
                begin
                    next_r.state = H_HOLD;
                    next_r.timer = '0;
                end
                else if (got_error)
                begin
                    // retry count saturates so it cannot wrap to zero
                    next_r.state = H_SEND;
                    if (r.retries != 4'hf)
                    begin
                        next_r.retries = r.retries + 4'h1;
                    end
                end
                else if (wait_expired)
                begin
                    // a lost ok is treated as an ok
                    next_r.state = H_HOLD;
                    next_r.timer = '0;
                    next_r.timed_out = 1'b1;
                end
            end
            H_HOLD:
            begin
                // fixed hold-off lets the card finish its own power-off
                // no early exit, even after a timeout: the card gets the full window
                next_r.timer = r.timer + 32'h1;
                if (hold_done)
                begin
                    next_r.state = H_IDLE;
                    // supply cut and pin released together, handshake done
                    next_r.supply = 1'b0;
                    next_r.keep_out = 1'b0;
                    next_r.keep_oe = !(release_hiz || tied_mode);
                    next_r.timer = '0;
                end
            end
            default:
            begin
                next_r.state = H_IDLE;
            end
        endcase
    end

    // ****************************************
    // state register
    // ****************************************
    // reset image: pin driven low, supply off, counters clear
    localparam mcps_host_s HOST_RST = '{
        state: H_IDLE,
        keep_out: `MCPS_KEEP_OUT_RST,
        keep_oe: `MCPS_KEEP_OE_RST,
        supply: 1'b0,
        cmd_valid: 1'b0,
        cmd_code: CMD_NONE,
        timer: 32'h0,
        retries: 4'h0,
        timed_out: 1'b0
    };

    // reset drives the pin low so the card stays off
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            r <= HOST_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // pin drive and enable straight from flops: a glitch
    // on the enable would briefly power the card
    assign link.keep_on_out = r.keep_out;
    assign link.keep_on_oe = r.keep_oe;
    assign link.supply_en = r.supply;
    // command word is a flop, so the card sees a clean pulse
    assign link.cmd_valid = r.cmd_valid;
    assign link.cmd_code = r.cmd_code;
    // requests outside idle or on are dropped while the sequence runs
    assign busy = (r.state != H_IDLE) && (r.state != H_ON);
    assign card_powered = r.supply;
    assign shutdown_timed_out = r.timed_out;
    assign error_retries = r.retries;

endmodule
`default_nettype wire

/* bench/mcps_link_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module mcps_link_chk
    import mcps_pkg::*;
#(
    parameter int unsigned HOLD_OFF_CYC = 50,
    parameter int unsigned RSP_TIMEOUT_CYC = 40
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic keep_on_out,
    input wire logic keep_on_oe,
    input wire logic keep_on_level,
    input wire logic supply_en,
    input wire logic cmd_valid,
    input var mcps_cmd_e cmd_code,
    input wire logic rsp_valid,
    input var mcps_rsp_e rsp_code
);
    // ****************************************
    // link checks
    // ****************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // command in flight, and cycles since the last command or reply
    logic pending;
    logic [31:0] since;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pending <= 1'b0;
            since <= 32'h0;
        end
        else
        begin
            pending <= cmd_valid | (pending & ~rsp_valid & supply_en); // lost reply clears on power drop
            since <= (cmd_valid | rsp_valid) ? 32'h0 : since + 32'h1;
        end
    end

    a_pin_low_reset: assert property (disable iff (1'b0) rst |=> keep_on_oe && !keep_on_out && !supply_en)
        else $error("pin or supply not off after reset");
    a_pin_high_on: assert property ($rose(supply_en) |-> keep_on_out && keep_on_level)
        else $error("supply up without pin high");
    a_cmd_code_min: assert property (cmd_valid |-> cmd_code == CMD_FUNC_MIN && supply_en ##1 !cmd_valid)
        else $error("bad shutdown command");
    a_one_outstanding: assert property (cmd_valid |-> !pending)
        else $error("command while one in flight");
    a_rsp_needs_cmd: assert property (rsp_valid |-> pending && supply_en ##1 !rsp_valid)
        else $error("reply without command");
    a_err_resend: assert property (rsp_valid && rsp_code == RSP_ERROR |->
        ##2 cmd_valid && cmd_code == CMD_FUNC_MIN)
        else $error("no resend after error");
    a_ok_holds_supply: assert property (rsp_valid && rsp_code == RSP_OK |-> supply_en [*8])
        else $error("supply cut right after ok");
    a_fall_after_hold: assert property ($fell(supply_en) |->
        since >= HOLD_OFF_CYC - 2 && since <= HOLD_OFF_CYC + RSP_TIMEOUT_CYC + 8)
        else $error("supply cut outside hold-off window");
    a_pin_released: assert property ($fell(supply_en) |-> !(keep_on_oe && keep_on_out))
        else $error("pin still high after supply off");
endmodule
`default_nettype wire

/* bench/modem_card_power_off_sequencer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mcps_regs.svh"
module modem_card_power_off_sequencer_tb;
    import mcps_pkg::*;
    // short hold-off and timeout keep the run small
    localparam int HOLD = 4000;
    localparam int RTO = 40;
    localparam int STEP = `MCPS_STEP_CYC;
    // selectors for the pulse task
    localparam int REQ_ON = 0, REQ_OFF = 1, FW_DONE = 2, FW_FAIL = 3;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic power_on_req = 1'b0;
    logic power_off_req = 1'b0;
    logic tied_mode = 1'b0;
    logic release_hiz = 1'b0;
    logic tasks_done = 1'b0;
    logic tasks_fail = 1'b0;
    logic busy, card_powered, shutdown_timed_out, tasks_start;
    logic pmu_on, rtc_on, core_on, card_rst, sysclk_req, card_running;
    logic [3:0] error_retries;
    int checked = 0;
    int bad_count = 0;

    // ****************************************
    // both ends and the checker
    // ****************************************
    mcps_link_if link();
    mcps_host #(.HOLD_OFF_CYC(HOLD), .RSP_TIMEOUT_CYC(RTO)) u_mcps_host (.core_clk(core_clk), .rst(rst),
        .link(link.host), .power_on_req(power_on_req), .power_off_req(power_off_req), .tied_mode(tied_mode),
        .release_hiz(release_hiz), .busy(busy), .card_powered(card_powered),
        .shutdown_timed_out(shutdown_timed_out), .error_retries(error_retries));
    mcps_card u_mcps_card (.core_clk(core_clk), .rst(rst), .link(link.card), .tasks_done(tasks_done),
        .tasks_fail(tasks_fail), .tasks_start(tasks_start), .pmu_supply_regulator_en(pmu_on),
        .rtc_supply_regulator_en(rtc_on), .core_regs_en(core_on), .card_rst(card_rst),
        .sysclk_req(sysclk_req), .card_running(card_running));
    mcps_link_chk #(.HOLD_OFF_CYC(HOLD), .RSP_TIMEOUT_CYC(RTO)) u_mcps_link_chk (.core_clk(core_clk),
        .rst(rst), .keep_on_out(link.keep_on_out), .keep_on_oe(link.keep_on_oe),
        .keep_on_level(link.keep_on_level), .supply_en(link.supply_en), .cmd_valid(link.cmd_valid),
        .cmd_code(link.cmd_code), .rsp_valid(link.rsp_valid), .rsp_code(link.rsp_code));

    // 125 MHz host clock
    always #4 core_clk = ~core_clk;

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask

    // bounded wait, sampled just after each edge so flops have settled
    task automatic wait_for(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        while (s !== v && n < lim)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check(s, v, "wait");
    endtask

    // one-cycle request on the selected input, sampled at the second edge
    task automatic pulse(input int sel);
        @(posedge core_clk);
        power_on_req <= (sel == REQ_ON);
        power_off_req <= (sel == REQ_OFF);
        tasks_done <= (sel == FW_DONE);
        tasks_fail <= (sel == FW_FAIL);
        @(posedge core_clk);
        power_on_req <= 1'b0;
        power_off_req <= 1'b0;
        tasks_done <= 1'b0;
        tasks_fail <= 1'b0;
        #1;
    endtask

    task automatic conclude();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic power_up();
        pulse(REQ_ON);
        check({link.supply_en, link.keep_on_out, link.keep_on_oe, link.keep_on_level},
            {2'h3, ~tied_mode, 1'b1}, "power on");
        wait_for(card_running, 1'b1, STEP + 20);
        check({pmu_on, rtc_on, core_on, sysclk_req, card_rst}, 5'h1e, "card up");
        check({shutdown_timed_out, error_retries}, 5'h0, "counters cleared");
    endtask

    // error reply, resend, ok, card park, hold-off, pin to hi-z
    task automatic shut_with_retry();
        int t_ok;
        @(posedge core_clk);
        release_hiz <= 1'b1;
        pulse(REQ_OFF);
        check(busy, 1'b1, "busy");
        wait_for(link.cmd_valid, 1'b1, 4);
        check(link.cmd_code, CMD_FUNC_MIN, "cmd");
        wait_for(tasks_start, 1'b1, 4);
        pulse(FW_FAIL);
        wait_for(link.rsp_valid, 1'b1, 4);
        check(link.rsp_code, RSP_ERROR, "error reply");
        wait_for(link.cmd_valid, 1'b1, 4);
        check({link.cmd_code, error_retries}, {CMD_FUNC_MIN, 4'h1}, "resend");
        wait_for(tasks_start, 1'b1, 4);
        check(link.rsp_valid, 1'b0, "no early ok");
        pulse(FW_DONE);
        wait_for(link.rsp_valid, 1'b1, 4);
        check(link.rsp_code, RSP_OK, "ok reply");
        t_ok = int'($time);
        // a power-on request during the hold-off must be dropped
        pulse(REQ_ON);
        check(busy, 1'b1, "on ignored while busy");
        wait_for(sysclk_req, 1'b0, 3 * STEP + 10);
        check({pmu_on, rtc_on, core_on, card_rst, link.supply_en, card_powered}, 6'h37, "parked");
        wait_for(link.supply_en, 1'b0, HOLD);
        check((int'($time) - t_ok) / `MCPS_CLK_PERIOD_NS >= HOLD, 1'b1, "hold off");
        check({link.keep_on_oe, link.keep_on_level, busy}, 3'h0, "released");
        wait_for(pmu_on, 1'b0, 6);
        check({rtc_on, card_running}, 2'h0, "card off");
    endtask

    // tied-high pin, card never replies
    task automatic shut_by_timeout();
        @(posedge core_clk);
        release_hiz <= 1'b0;
        tied_mode <= 1'b1;
        link.board_pullup <= 1'b1;
        power_up();
        pulse(REQ_OFF);
        wait_for(tasks_start, 1'b1, 6);
        wait_for(shutdown_timed_out, 1'b1, RTO + 8);
        check({link.rsp_valid, link.supply_en, busy}, 3'h3, "waits hold");
        wait_for(link.supply_en, 1'b0, HOLD + 8);
        wait_for(pmu_on, 1'b0, 6);
    endtask

    task automatic mid_reset();
        power_up();
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        check({link.keep_on_oe, link.keep_on_out, link.supply_en, busy}, 4'h8, "reset again");
        wait_for(pmu_on, 1'b0, 6);
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial
    begin
        link.board_pullup <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        check({link.keep_on_oe, link.keep_on_out, link.supply_en, busy}, 4'h8, "after reset");
        power_up();
        shut_with_retry();
        shut_by_timeout();
        mid_reset();
        conclude();
    end

    // the run needs about 12000 cycles
    initial
    begin
        repeat (40000) @(posedge core_clk);
        bad_count++;
        conclude();
    end
endmodule
`default_nettype wire
